//--- core/dtc_pkg.sv
package dtc_pkg;

	// Register addresses on the special function port.
	localparam logic [7:0] ADDR_CTRL     = 8'h88;
	localparam logic [7:0] ADDR_MODE     = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW   = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW   = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH  = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH  = 8'h8d;
	localparam logic [7:0] ADDR_FREQ     = 8'h8e;
	localparam logic [7:0] ADDR_INT_EN   = 8'ha8;

	// Field positions in the control register.
	localparam int CTRL_TF1_BIT = 7;
	localparam int CTRL_TR1_BIT = 6;
	localparam int CTRL_TF0_BIT = 5;
	localparam int CTRL_TR0_BIT = 4;

	// Field positions in the mode register.
	localparam int MODE_T1_SRC_BIT = 6;
	localparam int MODE_T1_LSB     = 4;
	localparam int MODE_T0_SRC_BIT = 2;
	localparam int MODE_T0_LSB     = 0;

	// Field positions in the frequency and interrupt enable registers.
	localparam int FREQ_T0_BIT  = 0;
	localparam int FREQ_T1_BIT  = 1;
	localparam int INTEN_T0_BIT = 1;
	localparam int INTEN_T1_BIT = 3;

	// Reset value shared by every register of the block.
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// System clock divide ratio for the slow timer clock.
	localparam int DIV_RATIO = 12;

	// Operating modes of the two-bit mode fields.
	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_t;

endpackage : dtc_pkg

//--- core/dtc_timers.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps

// Behaviour
// - Timer 0 has four modes via two bits.
// - Mode codes: 13-bit, 16-bit, reload, split/stop.
// - 13-bit: high byte bits 12-5, low 4-0.
// - Timer 0 overflow sets flag; interrupt if enabled.
// - Interrupt acceptance clears the overflow flag.
// - Counter source: pin falling edge increments timer 0.
// - Timer source: divided system clock for timer 0.
// - Divider bit zero gives clock/12, one undivided.
// - Divider selects are frequency register bits 0,1.
// - Run bit resumes from held count.
// - 16-bit mode uses all bits of both bytes.
// - Reload mode: overflow sets flag, low reloads from high.
// - Reload byte stays unchanged after reload.
// - Split low byte uses timer 0 controls.
// - Split high byte: timer clock, timer 1 controls.
// - Split mode stops timer 1's own counter.
// - Timer 1 modes from mode bits 5 and 4.
// - Timer 1 mode code 11 halts it.
// - Timer 1 13-bit layout like timer 0.
// - Timer 1 counts pin edges or divided clock.
// - Timer 1 overflow sets flag; interrupt if enabled.
// - Timer 1 reload mode copies high into low.
// - Timer 1 run bit resumes from held count.
module dtc_timers
	import dtc_pkg::*;
#(
	parameter int DIV = DIV_RATIO
)(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       srst,
	// Register port.
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// External count pins.
	input  wire logic       timer0_ext_pin,
	input  wire logic       timer1_ext_pin,
	// Interrupt requests and acceptance pulses.
	output logic            irq0,
	output logic            irq1,
	input  wire logic       ack0,
	input  wire logic       ack1
);

	// Count registers.
	logic [7:0] timer0_low_byte;         // Timer 0 low count byte.
	logic [7:0] timer0_high_byte;        // Timer 0 high count or reload byte.
	logic [7:0] timer1_low_byte;         // Timer 1 low count byte.
	logic [7:0] timer1_high_byte;        // Timer 1 high count or reload byte.
	// Control and configuration state.
	logic       timer0_overflow_flag;    // Timer 0 overflow flag.
	logic       timer1_overflow_flag;    // Timer 1 overflow flag.
	logic       timer0_run;              // Timer 0 run bit.
	logic       timer1_run;              // Timer 1 run bit.
	logic [7:0] timer_mode_reg;          // Mode register.
	logic [1:0] timer_freq_ctrl_reg;     // Divider selects.
	logic [1:0] int_enable;              // Timer interrupt enables.
	// Decoded controls.
	dtc_mode_t  mode0;                   // Timer 0 mode.
	dtc_mode_t  mode1;                   // Timer 1 mode.
	logic       timer0_count_source_sel; // Timer 0 pin source when high.
	logic       timer1_count_source_sel; // Timer 1 pin source when high.
	logic       timer0_divider_sel;      // Timer 0 undivided clock when high.
	logic       timer1_divider_sel;      // Timer 1 undivided clock when high.
	// Prescaler and pin logic.
	logic [3:0] div_cnt;                 // Divide-by-ratio counter.
	logic       tick_slow;               // One pulse per ratio cycles.
	logic [1:0] pin0_sync;               // Pin 0 synchroniser.
	logic [1:0] pin1_sync;               // Pin 1 synchroniser.
	logic       pin0_prev;               // Pin 0 delayed sample.
	logic       pin1_prev;               // Pin 1 delayed sample.
	logic       fall0;                   // Pin 0 falling edge.
	logic       fall1;                   // Pin 1 falling edge.
	// Increment and overflow events.
	logic       tick0;                   // Timer 0 clock tick.
	logic       tick1;                   // Timer 1 clock tick.
	logic       inc0;                    // Timer 0 increment.
	logic       inc0_high;               // Split high byte increment.
	logic       inc1;                    // Timer 1 increment.
	logic       ovf0;                    // Timer 0 overflow event.
	logic       ovf0_high;               // Split high byte overflow event.
	logic       ovf1;                    // Timer 1 overflow event.
	logic [7:0] next_t0_low;             // Timer 0 low next value.
	logic [7:0] next_t0_high;            // Timer 0 high next value.
	logic [7:0] next_t1_low;             // Timer 1 low next value.
	logic [7:0] next_t1_high;            // Timer 1 high next value.
	// Write strobes.
	logic       wr_ctrl;                 // Control register write.
	logic       wr_t0;                   // Timer 0 byte write.
	logic       wr_t1;                   // Timer 1 byte write.

	// One count step for modes 13-bit, 16-bit and reload; returns overflow, high, low.
	function automatic logic [16:0] dtc_step(
		input dtc_mode_t  mode,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [13:0] s13;
		logic [16:0] s16;
		logic        wrap;
		s13  = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16  = {1'b0, hi, lo} + 17'h00001;
		wrap = (lo == 8'hff);
		case (mode)
			DTC_MODE_13BIT:  dtc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			DTC_MODE_16BIT:  dtc_step = s16;
			DTC_MODE_RELOAD: dtc_step = {wrap, hi, wrap ? hi : lo + 8'h01};
			default:         dtc_step = {1'b0, hi, lo};
		endcase
	endfunction : dtc_step

	// Field decode of the mode and frequency registers.
	assign mode0 = dtc_mode_t'(timer_mode_reg[MODE_T0_LSB +: 2]);
	assign mode1 = dtc_mode_t'(timer_mode_reg[MODE_T1_LSB +: 2]);
	assign timer0_count_source_sel = timer_mode_reg[MODE_T0_SRC_BIT];
	assign timer1_count_source_sel = timer_mode_reg[MODE_T1_SRC_BIT];
	assign timer0_divider_sel      = timer_freq_ctrl_reg[FREQ_T0_BIT];
	assign timer1_divider_sel      = timer_freq_ctrl_reg[FREQ_T1_BIT];

	// Write decode; a byte write takes priority over counting in that cycle.
	assign wr_ctrl = wr && (addr == ADDR_CTRL);
	assign wr_t0   = wr && (addr == ADDR_T0_LOW || addr == ADDR_T0_HIGH);
	assign wr_t1   = wr && (addr == ADDR_T1_LOW || addr == ADDR_T1_HIGH);

	// Prescaler producing one slow tick every DIV system clocks.
	always_ff @(posedge clk)
	begin
		if (srst || tick_slow)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end
	assign tick_slow = (div_cnt == 4'(DIV - 1));

	// Pin synchronisers; edge detection reads only the second stage onward.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin0_sync <= 2'h3;
			pin1_sync <= 2'h3;
			pin0_prev <= 1'b1;
			pin1_prev <= 1'b1;
		end
		else
		begin
			pin0_sync <= {pin0_sync[0], timer0_ext_pin};
			pin1_sync <= {pin1_sync[0], timer1_ext_pin};
			pin0_prev <= pin0_sync[1];
			pin1_prev <= pin1_sync[1];
		end
	end
	assign fall0 = pin0_prev && !pin0_sync[1];
	assign fall1 = pin1_prev && !pin1_sync[1];

	// Increment selection from source, divider and run bits.
	assign tick0     = timer0_divider_sel ? 1'b1 : tick_slow;
	assign tick1     = timer1_divider_sel ? 1'b1 : tick_slow;
	assign inc0      = timer0_run && (timer0_count_source_sel ? fall0 : tick0);
	assign inc0_high = timer1_run && tick1 && (mode0 == DTC_MODE_SPLIT);
	assign inc1      = timer1_run && (mode1 != DTC_MODE_SPLIT) && (mode0 != DTC_MODE_SPLIT) &&
	                   (timer1_count_source_sel ? fall1 : tick1);

	// Next count values and overflow events.
	always_comb
	begin
		logic [16:0] step0;
		logic [16:0] step1;
		step0        = dtc_step(mode0, timer0_high_byte, timer0_low_byte);
		step1        = dtc_step(mode1, timer1_high_byte, timer1_low_byte);
		next_t0_low  = timer0_low_byte;
		next_t0_high = timer0_high_byte;
		ovf0         = 1'b0;
		ovf0_high    = 1'b0;
		if (mode0 == DTC_MODE_SPLIT)
		begin
			// Two independent 8-bit counters.
			if (inc0)
			begin
				next_t0_low = timer0_low_byte + 8'h01;
				ovf0        = (timer0_low_byte == 8'hff);
			end
			if (inc0_high)
			begin
				next_t0_high = timer0_high_byte + 8'h01;
				ovf0_high    = (timer0_high_byte == 8'hff);
			end
		end
		else if (inc0)
		begin
			// One counter spanning both bytes, except the low byte alone in reload mode.
			{ovf0, next_t0_high, next_t0_low} = step0;
		end
		next_t1_low  = timer1_low_byte;
		next_t1_high = timer1_high_byte;
		ovf1         = 1'b0;
		if (inc1)
		begin
			{ovf1, next_t1_high, next_t1_low} = step1;
		end
	end

	// Timer 0 count bytes; counting holds the value while stopped.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer0_low_byte  <= RESET_BYTE;
			timer0_high_byte <= RESET_BYTE;
		end
		else if (wr_t0)
		begin
			if (addr == ADDR_T0_LOW)
				timer0_low_byte <= wdata;
			else
				timer0_high_byte <= wdata;
		end
		else
		begin
			timer0_low_byte  <= next_t0_low;
			timer0_high_byte <= next_t0_high;
		end
	end

	// Timer 1 count bytes.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer1_low_byte  <= RESET_BYTE;
			timer1_high_byte <= RESET_BYTE;
		end
		else if (wr_t1)
		begin
			if (addr == ADDR_T1_LOW)
				timer1_low_byte <= wdata;
			else
				timer1_high_byte <= wdata;
		end
		else
		begin
			timer1_low_byte  <= next_t1_low;
			timer1_high_byte <= next_t1_high;
		end
	end

	// Overflow flags; a hardware set wins over acceptance and software writes.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer0_overflow_flag <= 1'b0;
			timer1_overflow_flag <= 1'b0;
		end
		else
		begin
			if (ovf0)
				timer0_overflow_flag <= 1'b1;
			else if (ack0)
				timer0_overflow_flag <= 1'b0;
			else if (wr_ctrl)
				timer0_overflow_flag <= wdata[CTRL_TF0_BIT];
			if (ovf1 || ovf0_high)
				timer1_overflow_flag <= 1'b1;
			else if (ack1)
				timer1_overflow_flag <= 1'b0;
			else if (wr_ctrl)
				timer1_overflow_flag <= wdata[CTRL_TF1_BIT];
		end
	end

	// Software configuration registers.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer0_run          <= 1'b0;
			timer1_run          <= 1'b0;
			timer_mode_reg      <= RESET_BYTE;
			timer_freq_ctrl_reg <= 2'h0;
			int_enable          <= 2'h0;
		end
		else if (wr)
		begin
			case (addr)
				ADDR_CTRL:
				begin
					timer0_run <= wdata[CTRL_TR0_BIT];
					timer1_run <= wdata[CTRL_TR1_BIT];
				end
				ADDR_MODE:   timer_mode_reg <= wdata & 8'h77;
				ADDR_FREQ:   timer_freq_ctrl_reg <= wdata[1:0];
				ADDR_INT_EN: int_enable <= {wdata[INTEN_T1_BIT], wdata[INTEN_T0_BIT]};
				default:     ;
			endcase
		end
	end

	// Read data, valid in the cycle after the read strobe only.
	always_ff @(posedge clk)
	begin
		if (srst || !rd)
			rdata <= 8'h00;
		else
		begin
			case (addr)
				ADDR_CTRL:    rdata <= {timer1_overflow_flag, timer1_run,
				                        timer0_overflow_flag, timer0_run, 4'h0};
				ADDR_MODE:    rdata <= timer_mode_reg;
				ADDR_T0_LOW:  rdata <= timer0_low_byte;
				ADDR_T1_LOW:  rdata <= timer1_low_byte;
				ADDR_T0_HIGH: rdata <= timer0_high_byte;
				ADDR_T1_HIGH: rdata <= timer1_high_byte;
				ADDR_FREQ:    rdata <= {6'h00, timer_freq_ctrl_reg};
				ADDR_INT_EN:  rdata <= {4'h0, int_enable[1], 1'b0, int_enable[0], 1'b0};
				default:      rdata <= 8'h00;
			endcase
		end
	end

	// Interrupt requests from flag and enable.
	assign irq0 = timer0_overflow_flag && int_enable[0];
	assign irq1 = timer1_overflow_flag && int_enable[1];

	// Checks of the counting behaviour.
	property p_reload0;
		@(posedge clk) disable iff (srst)
		(inc0 && mode0 == DTC_MODE_RELOAD && timer0_low_byte == 8'hff && !wr_t0)
		|=> (timer0_low_byte == $past(timer0_high_byte)) &&
		    $stable(timer0_high_byte) && timer0_overflow_flag;
	endproperty
	a_reload0: assert property (p_reload0) else $error("reload failed");

	property p_wrap16;
		@(posedge clk) disable iff (srst)
		(inc0 && mode0 == DTC_MODE_16BIT && !wr_t0 &&
		 {timer0_high_byte, timer0_low_byte} == 16'hffff)
		|=> ({timer0_high_byte, timer0_low_byte} == 16'h0000) && timer0_overflow_flag;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-bit wrap failed");

	property p_carry13;
		@(posedge clk) disable iff (srst)
		(inc0 && mode0 == DTC_MODE_13BIT && !wr_t0 && timer0_low_byte[4:0] == 5'h1f)
		|=> timer0_high_byte == $past(timer0_high_byte) + 8'h01 &&
		    timer0_low_byte[4:0] == 5'h00;
	endproperty
	a_carry13: assert property (p_carry13) else $error("13-bit carry failed");

	property p_hold;
		@(posedge clk) disable iff (srst)
		(!timer0_run && !timer1_run && !wr_t0) |=> $stable(timer0_low_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("stopped timer moved");

	property p_t1_stop;
		@(posedge clk) disable iff (srst)
		(mode0 == DTC_MODE_SPLIT && !wr_t1)
		|=> $stable(timer1_low_byte) && $stable(timer1_high_byte);
	endproperty
	a_t1_stop: assert property (p_t1_stop) else $error("timer 1 ran in split");

	property p_slow_tick;
		@(posedge clk) disable iff (srst)
		tick_slow |=> !tick_slow [*8];
	endproperty
	a_slow_tick: assert property (p_slow_tick) else $error("divider too fast");

	property p_edge;
		@(posedge clk) disable iff (srst)
		(pin0_prev && !pin0_sync[1] && timer0_run && timer0_count_source_sel &&
		 mode0 == DTC_MODE_16BIT && !wr_t0 && timer0_low_byte != 8'hff)
		|=> timer0_low_byte == $past(timer0_low_byte) + 8'h01;
	endproperty
	a_edge: assert property (p_edge) else $error("pin edge not counted");

	property p_ack;
		@(posedge clk) disable iff (srst)
		(ack0 && !ovf0 && !wr_ctrl) |=> !timer0_overflow_flag ##1 1'b1;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear");

	property p_set_wins;
		@(posedge clk) disable iff (srst)
		(ovf0 && (ack0 || wr_ctrl)) |=> timer0_overflow_flag && (irq0 == int_enable[0]);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("overflow lost");

	property p_split_hi;
		@(posedge clk) disable iff (srst)
		(inc0_high && timer0_high_byte == 8'hff && !wr_t0)
		|=> timer1_overflow_flag && timer0_high_byte == 8'h00;
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split overflow");

	// Coverage of the main scenarios.
	c_reload:  cover property (@(posedge clk) disable iff (srst)
		inc0 && mode0 == DTC_MODE_RELOAD && timer0_low_byte == 8'hff);
	c_split:   cover property (@(posedge clk) disable iff (srst) ovf0_high);
	c_edge1:   cover property (@(posedge clk) disable iff (srst) inc1 && timer1_count_source_sel);
	c_ovf13:   cover property (@(posedge clk) disable iff (srst)
		ovf1 && mode1 == DTC_MODE_13BIT);

endmodule : dtc_timers

//--- dv/dtc_pulse_src.sv
`timescale 1ns/10ps

// Event source on one count pin; it idles high so no false edge is seen.
module dtc_pulse_src (
	// Clock.
	input  wire logic clk,
	// Count pin.
	output logic      pin
);

	// The pin rests high between bursts.
	initial pin = 1'b1;

	// Sends n falling edges, low held for two cycles, high for three between them.
	task automatic send(input int n);
		repeat (n)
		begin
			@(posedge clk);
			pin <= 1'b0;
			repeat (2) @(posedge clk);
			pin <= 1'b1;
			repeat (2) @(posedge clk);
		end
	endtask : send

endmodule : dtc_pulse_src

//--- dv/dual_timer_counter_modes_tb.sv
`timescale 1ns/10ps

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

// Drives the timer pair through its register port and count pins.
module dual_timer_counter_modes_tb;
	import dtc_pkg::*;

	logic       clk   = 1'b0;  // System clock.
	logic       srst  = 1'b1;  // Synchronous reset.
	logic [7:0] addr  = 8'h00; // Register address.
	logic [7:0] wdata = 8'h00; // Write data.
	logic       wr    = 1'b0;  // Write strobe.
	logic       rd    = 1'b0;  // Read strobe.
	logic [7:0] rdata;         // Read data.
	logic       pin0, pin1;    // Count pins.
	logic       irq0, irq1;    // Interrupt requests.
	logic       ack0  = 1'b0;  // Acceptance pulses.
	logic       ack1  = 1'b0;
	logic       i0s, i1s;      // Requests seen while running.
	logic [7:0] rv;            // Last read value.
	int         n_compared = 0;
	int         mismatches = 0;

	// The clock toggles every half period of 20 ns.
	always #20 clk = ~clk;

	dtc_timers dtc_timers_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .timer0_ext_pin(pin0), .timer1_ext_pin(pin1),
		.irq0(irq0), .irq1(irq1), .ack0(ack0), .ack1(ack1));
	dtc_pulse_src dtc_pulse_src_inst (.clk(clk), .pin(pin0));
	dtc_pulse_src dtc_pulse_src_inst_b (.clk(clk), .pin(pin1));

	// One write cycle.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// One read cycle; data is taken in the cycle after the strobe.
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
		`CHK(nm, e, rv & m)
	endtask : chk_rd

	// Loads both count pairs while stopped.
	task automatic ld(input logic [7:0] l0, h0, l1, h1);
		wr_reg(ADDR_T0_LOW, l0);
		wr_reg(ADDR_T0_HIGH, h0);
		wr_reg(ADDR_T1_LOW, l1);
		wr_reg(ADDR_T1_HIGH, h1);
	endtask : ld

	// Runs for m+2 count edges, catching the requests before the stop.
	task automatic run_for(input logic [7:0] c, input int m);
		wr_reg(ADDR_CTRL, c);
		repeat (m) @(posedge clk);
		#1 i0s = irq0;
		i1s = irq1;
		wr_reg(ADDR_CTRL, 8'h00);
	endtask : run_for

	// Reset values, unmapped place and reserved bits.
	task automatic t_regs;
		logic [7:0] ra [9];
		ra = '{ADDR_CTRL, ADDR_MODE, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH,
			ADDR_T1_HIGH, ADDR_FREQ, ADDR_INT_EN, 8'h90};
		foreach (ra[i]) chk_rd("reset", ra[i], 8'hff, RESET_BYTE);
		`CHK("irq0", 1'b0, irq0)
		wr_reg(8'h90, 8'hff);
		chk_rd("unmapped", 8'h90, 8'hff, 8'h00);
		wr_reg(ADDR_MODE, 8'hff);
		chk_rd("mode", ADDR_MODE, 8'hff, 8'h77);
		wr_reg(ADDR_FREQ, 8'hff);
		chk_rd("freq", ADDR_FREQ, 8'hff, 8'h03);
		wr_reg(ADDR_INT_EN, 8'hff);
		chk_rd("inten", ADDR_INT_EN, 8'hff, 8'h0a);
		wr_reg(ADDR_MODE, 8'h00);
		$display("test regs done");
	endtask : t_regs

	// Both timers 16-bit, fast clock, resume and carry.
	task automatic t_16;
		wr_reg(ADDR_MODE, 8'h11);
		wr_reg(ADDR_FREQ, 8'h03);
		ld(8'h00, 8'h00, 8'h00, 8'h00);
		run_for(8'h50, 8);
		chk_rd("t0 low", ADDR_T0_LOW, 8'hff, 8'h0a);
		chk_rd("t1 low", ADDR_T1_LOW, 8'hff, 8'h0a);
		run_for(8'h50, 8);
		chk_rd("t0 resume", ADDR_T0_LOW, 8'hff, 8'h14);
		chk_rd("t1 resume", ADDR_T1_LOW, 8'hff, 8'h14);
		ld(8'hfb, 8'h12, 8'h00, 8'h00);
		run_for(8'h10, 8);
		chk_rd("t0 carry lo", ADDR_T0_LOW, 8'hff, 8'h05);
		chk_rd("t0 carry hi", ADDR_T0_HIGH, 8'hff, 8'h13);
		$display("test 16bit done");
	endtask : t_16

	// Both timers 13-bit: carry out of five bits and full wrap.
	task automatic t_13;
		wr_reg(ADDR_MODE, 8'h00);
		ld(8'hfe, 8'h00, 8'h1e, 8'h04);
		run_for(8'h50, 8);
		chk_rd("t0 lo13", ADDR_T0_LOW, 8'h1f, 8'h08);
		chk_rd("t0 hi13", ADDR_T0_HIGH, 8'hff, 8'h01);
		chk_rd("t1 lo13", ADDR_T1_LOW, 8'h1f, 8'h08);
		chk_rd("t1 hi13", ADDR_T1_HIGH, 8'hff, 8'h05);
		ld(8'h1e, 8'hff, 8'h1e, 8'hff);
		run_for(8'h50, 2);
		`CHK("irq0 wrap13", 1'b1, i0s)
		`CHK("irq1 wrap13", 1'b1, i1s)
		chk_rd("t0 wrap lo", ADDR_T0_LOW, 8'h1f, 8'h02);
		chk_rd("t0 wrap hi", ADDR_T0_HIGH, 8'hff, 8'h00);
		$display("test 13bit done");
	endtask : t_13

	// Flag and acceptance for both requests, mask for request 0 only.
	task automatic t_irq;
		int k;
		wr_reg(ADDR_MODE, 8'h01);
		ld(8'hff, 8'hff, 8'h00, 8'h00);
		// Flags left over from the wrap scenario are cleared, so the wait below sees a fresh set.
		wr_reg(ADDR_CTRL, 8'h00);
		#1 `CHK("irq0 cleared", 1'b0, irq0)
		wr_reg(ADDR_CTRL, 8'h10);
		for (k = 0; k < 20 && irq0 !== 1'b1; k++) @(posedge clk);
		if (k == 20)
		begin
			mismatches++;
			print_verdict();
		end
		chk_rd("flag0", ADDR_CTRL, 8'h20, 8'h20);
		@(posedge clk);
		ack0 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		#1 `CHK("irq0 ack", 1'b0, irq0)
		wr_reg(ADDR_INT_EN, 8'h00);
		wr_reg(ADDR_CTRL, 8'ha0);
		#1 `CHK("irq0 masked", 1'b0, irq0)
		wr_reg(ADDR_INT_EN, 8'h0a);
		#1 `CHK("irq1 on", 1'b1, irq1)
		@(posedge clk);
		ack1 <= 1'b1;
		@(posedge clk);
		ack1 <= 1'b0;
		#1 `CHK("irq1 ack", 1'b0, irq1)
		`CHK("irq0 kept", 1'b1, irq0)
		wr_reg(ADDR_CTRL, 8'h00);
		$display("test irq done");
	endtask : t_irq

	// Divider selections: 24 edges give 24 fast or 2 slow ticks.
	task automatic t_div;
		wr_reg(ADDR_MODE, 8'h11);
		wr_reg(ADDR_FREQ, 8'h01);
		ld(8'h00, 8'h00, 8'h00, 8'h00);
		run_for(8'h50, 22);
		chk_rd("t0 fast", ADDR_T0_LOW, 8'hff, 8'h18);
		chk_rd("t1 slow", ADDR_T1_LOW, 8'hff, 8'(8'h18 / DIV_RATIO));
		wr_reg(ADDR_FREQ, 8'h02);
		ld(8'h00, 8'h00, 8'h00, 8'h00);
		run_for(8'h50, 22);
		chk_rd("t0 slow", ADDR_T0_LOW, 8'hff, 8'(8'h18 / DIV_RATIO));
		chk_rd("t1 fast", ADDR_T1_LOW, 8'hff, 8'h18);
		$display("test div done");
	endtask : t_div

	// Auto-reload for both timers, reload byte left alone.
	task automatic t_reload;
		wr_reg(ADDR_MODE, 8'h22);
		wr_reg(ADDR_FREQ, 8'h03);
		ld(8'hfe, 8'hfd, 8'hfe, 8'hfd);
		run_for(8'h50, 8);
		`CHK("irq0 rl", 1'b1, i0s)
		`CHK("irq1 rl", 1'b1, i1s)
		chk_rd("t0 rl lo", ADDR_T0_LOW, 8'hff, 8'hff);
		chk_rd("t0 rl hi", ADDR_T0_HIGH, 8'hff, 8'hfd);
		chk_rd("t1 rl lo", ADDR_T1_LOW, 8'hff, 8'hff);
		chk_rd("t1 rl hi", ADDR_T1_HIGH, 8'hff, 8'hfd);
		$display("test reload done");
	endtask : t_reload

	// Pin edges counted once each on both timers.
	task automatic t_pin;
		wr_reg(ADDR_MODE, 8'h55);
		ld(8'h00, 8'h00, 8'h00, 8'h00);
		wr_reg(ADDR_CTRL, 8'h50);
		fork
			dtc_pulse_src_inst.send(5);
			dtc_pulse_src_inst_b.send(3);
		join
		repeat (4) @(posedge clk);
		wr_reg(ADDR_CTRL, 8'h00);
		chk_rd("t0 pin", ADDR_T0_LOW, 8'hff, 8'h05);
		chk_rd("t1 pin", ADDR_T1_LOW, 8'hff, 8'h03);
		$display("test pin done");
	endtask : t_pin

	// Split timer 0, then timer 1 halted by its own stop code.
	task automatic t_split;
		wr_reg(ADDR_MODE, 8'h13);
		ld(8'h00, 8'hfe, 8'h00, 8'h00);
		run_for(8'h50, 8);
		`CHK("irq1 split", 1'b1, i1s)
		`CHK("irq0 split", 1'b0, i0s)
		chk_rd("split lo", ADDR_T0_LOW, 8'hff, 8'h0a);
		chk_rd("split hi", ADDR_T0_HIGH, 8'hff, 8'h08);
		chk_rd("t1 held", ADDR_T1_LOW, 8'hff, 8'h00);
		wr_reg(ADDR_MODE, 8'h31);
		ld(8'h00, 8'h00, 8'h00, 8'h00);
		run_for(8'h50, 8);
		chk_rd("t1 stop", ADDR_T1_LOW, 8'hff, 8'h00);
		chk_rd("t0 run", ADDR_T0_LOW, 8'hff, 8'h0a);
		$display("test split done");
	endtask : t_split

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// Main sequence: twelve cycles of reset, then every scenario.
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_16();
		t_13();
		t_irq();
		t_div();
		t_reload();
		t_pin();
		t_split();
		print_verdict();
	end

endmodule : dual_timer_counter_modes_tb
